// >>> shared/ctl_regs_map.svh
`ifndef CTL_REGS_MAP_SVH
`define CTL_REGS_MAP_SVH

// register addresses
`define ADDR_FILTER_CTL     16'h0001
`define ADDR_CLKPWR_CTL     16'h0002
`define ADDR_OFFSET         16'h0003
`define ADDR_GAIN           16'h0004
`define ADDR_OVER_RANGE     16'h0005

// reset values
`define RST_FILTER_CTL      16'h001A
`define RST_CLKPWR_CTL      16'h009B
`define RST_OFFSET          16'h0000
`define RST_GAIN            16'hA000
`define RST_OVER_RANGE      16'hCCCC

// first control word fields
`define BIT_COEFF_LOAD      15
`define BIT_RD_OVR          14
`define BIT_RD_GAIN         13
`define BIT_RD_OFF          12
`define BIT_RD_STAT         11
`define BIT_CAL             10
`define BIT_SYNC            9
`define TAP_HI              8
`define TAP_LO              5
`define BIT_THIRD_USE       4
`define BIT_FIRST_USE       3
`define DEC_HI              2
`define DEC_LO              0
`define SELF_CLR_MASK       16'h01FF

// second control word fields
`define CDIV_HI             5
`define CDIV_LO             4
`define BIT_SHUTDOWN        3
`define BIT_LOWPWR          2
`define BIT_ALWAYS_ONE      1
`define BIT_AMP_OFF         0
`define CLKPWR_MASK         16'h003F

// timing
`define CLK_NS              50
`define CAL_TIME_US         14000
`define CAL_CYCLES          ((`CAL_TIME_US * 1000) / `CLK_NS)
`define SYNC_CYCLES         4

`endif

// >>> shared/ctl_regs_pkg.sv
/*
 control register bank types.
 assumes nothing of its surroundings.
*/
package ctl_regs_pkg;

	// bus write sequencer state
	typedef enum logic [1:0]
	{
		WAIT_ADDR,
		WAIT_DATA,
		COEFF_LOAD
	} wr_state_t;

	// next-read source
	typedef enum logic [2:0]
	{
		RD_RESULT,
		RD_OVR,
		RD_GAIN,
		RD_OFF,
		RD_STAT
	} rd_sel_t;

endpackage

// >>> logic/ctl_regs.sv
/*
 control register bank of a sigma-delta converter on a 16-bit parallel bus.
 holds the two control words and the offset, gain and over-range words,
 sequences address and data words, forwards filter coefficient words to the
 converter core while a download is open, and times the calibration and
 synchronisation routines from the control writes.
 the command bits of the first control word act once and are never stored.
 the readback bits arm exactly one read; every other read returns a result.
 assumes the host presents one-cycle write and read strobes synchronous to MCLK,
 data for reads is presented by the converter core on RESULT_IN,
 the status word is presented by the core on STATUS_IN in the same clock domain,
 and the core checks the coefficient checksum itself.
 no clock divider is built here; the divide code is only passed on.
 the host keeps to one readback bit per write and writes one to bit 1
 of the second control word; neither is enforced here.
*/
`timescale 1ns/1ns
`include "ctl_regs_map.svh"

module ctl_regs
	import ctl_regs_pkg::*;
#(
	parameter int CAL_CYCLES  = `CAL_CYCLES,
	parameter int SYNC_CYCLES = `SYNC_CYCLES
)
(
	// clock and reset
	input  wire logic        MCLK,
	input  wire logic        RST,
	// host bus
	input  wire logic        WR_STB,
	input  wire logic        RD_STB,
	input  wire logic [15:0] DATA_IN,
	output logic      [15:0] DATA_OUT,
	output logic             DATA_VALID,
	// converter core side
	input  wire logic [15:0] RESULT_IN,
	input  wire logic [15:0] STATUS_IN,
	output logic      [15:0] COEFF_WORD,
	output logic             COEFF_STB,
	output logic             LOAD_DONE,
	// filter configuration
	output logic      [3:0]  TAP_COUNT_FIELD,
	output logic             THIRD_STAGE_USE,
	output logic             FIRST_STAGE_USE,
	output logic      [2:0]  DECIMATION_FIELD,
	output logic             CAL_BUSY,
	output logic             SYNC_BUSY,
	// clock and power
	output logic      [1:0]  CLOCK_DIVIDE_FIELD,
	output logic             DEVICE_SHUTDOWN,
	output logic             REDUCED_POWER_SEL,
	output logic             INPUT_AMP_SHUTDOWN,
	// held correction values
	output logic      [15:0] OFFSET_VALUE,
	output logic      [15:0] GAIN_VALUE,
	output logic      [15:0] OVER_RANGE_VALUE
);

	// counter width covers the full calibration count
	// the sync counter shares it for simplicity
	localparam int CNT_W = $clog2(CAL_CYCLES + 1);

	wr_state_t         state_reg;          // write sequencer
	wr_state_t         state_next;
	logic [15:0]       addr_reg;           // latched address word
	logic [15:0]       filt_reg;           // first control word
	logic [15:0]       clkpwr_reg;         // second control word
	logic [15:0]       offset_reg;         // digital offset
	logic [15:0]       gain_reg;           // digital gain
	logic [15:0]       ovr_reg;            // over-range threshold
	rd_sel_t           rdsel_reg;          // pending readback source
	logic [6:0]        words_left_reg;     // coefficient words plus checksum
	logic [CNT_W-1:0]  cal_cnt_reg;        // calibration countdown
	logic [CNT_W-1:0]  sync_cnt_reg;       // synchronisation countdown
	logic [15:0]       dout_reg;
	logic              dvalid_reg;
	logic [15:0]       coeff_reg;
	logic              coeff_stb_reg;
	logic              done_reg;

	// decoded write targets
	// a data word is taken only after an address word
	// load-mode words bypass the register decode entirely
	// writes to unmapped addresses fall through and are dropped
	wire data_wr    = WR_STB && (state_reg == WAIT_DATA);
	wire coeff_wr   = WR_STB && (state_reg == COEFF_LOAD);
	wire wr_filt    = data_wr && (addr_reg == `ADDR_FILTER_CTL);
	wire wr_clkpwr  = data_wr && (addr_reg == `ADDR_CLKPWR_CTL);
	wire wr_offset  = data_wr && (addr_reg == `ADDR_OFFSET);
	wire wr_gain    = data_wr && (addr_reg == `ADDR_GAIN);
	wire wr_ovr     = data_wr && (addr_reg == `ADDR_OVER_RANGE);
	wire enter_load = wr_filt && DATA_IN[`BIT_COEFF_LOAD];
	wire [3:0] taps = DATA_IN[`TAP_HI:`TAP_LO];
	// code 2k+1 loads 6(k+1) coefficients of two words each, plus checksum
	// widest case is 48 coefficients, 97 words, which fits seven bits
	// even codes round up to the odd code above them
	wire [6:0] load_words = ({4'h0, taps[3:1]} + 7'h01) * 7'h0C + 7'h01;

	// next readback source from a control write
	// priority 14 over 13 over 12 over 11 if the host sets several
	// a control write with none set drops any pending selection
	rd_sel_t rd_pick;
	assign rd_pick = DATA_IN[`BIT_RD_OVR]  ? RD_OVR  :
			 DATA_IN[`BIT_RD_GAIN] ? RD_GAIN :
			 DATA_IN[`BIT_RD_OFF]  ? RD_OFF  :
			 DATA_IN[`BIT_RD_STAT] ? RD_STAT : RD_RESULT;

	// read data mux
	// status and result come live from the core, the rest from local storage
	wire [15:0] rd_data = (rdsel_reg == RD_OVR)  ? ovr_reg    :
			      (rdsel_reg == RD_GAIN) ? gain_reg   :
			      (rdsel_reg == RD_OFF)  ? offset_reg :
			      (rdsel_reg == RD_STAT) ? STATUS_IN  : RESULT_IN;

	// write sequencer next state
	// address and data words alternate; a download swallows the words
	// that follow until the checksum has arrived
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			WAIT_ADDR:
			begin
				if (WR_STB)
					state_next = WAIT_DATA;
			end
			WAIT_DATA:
			begin
				if (enter_load && (taps != 4'h0))
					state_next = COEFF_LOAD;
				else if (WR_STB)
					state_next = WAIT_ADDR;
			end
			// stay until the checksum word, the last one counted
			COEFF_LOAD:
			begin
				if (WR_STB && (words_left_reg == 7'h01))
					state_next = WAIT_ADDR;
			end
			default:
				state_next = WAIT_ADDR;
		endcase
	end

	// sequencer and address latch
	// address word is latched only while waiting for one
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			state_reg <= WAIT_ADDR;
			addr_reg  <= 16'h0000;
		end
		else
		begin
			state_reg <= state_next;
			if (WR_STB && (state_reg == WAIT_ADDR))
				addr_reg <= DATA_IN;
		end
	end

	// coefficient word counter and forwarding
	// the strobe and end pulse follow the taken word by one edge
	// the count stays idle outside a download
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			words_left_reg <= 7'h00;
			coeff_reg      <= 16'h0000;
			coeff_stb_reg  <= 1'b0;
			done_reg       <= 1'b0;
		end
		else
		begin
			coeff_stb_reg <= coeff_wr;
			done_reg      <= coeff_wr && (words_left_reg == 7'h01);
			if (enter_load)
				words_left_reg <= load_words;
			else if (coeff_wr)
				words_left_reg <= words_left_reg - 7'h01;
			if (coeff_wr)
				coeff_reg <= DATA_IN;
		end
	end

	// control word storage
	// offset, gain and over-range are plain stored words
	// bit 1 of the second word is stored as written
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			filt_reg   <= `RST_FILTER_CTL;
			clkpwr_reg <= `RST_CLKPWR_CTL;
			offset_reg <= `RST_OFFSET;
			gain_reg   <= `RST_GAIN;
			ovr_reg    <= `RST_OVER_RANGE;
		end
		else
		begin
			if (wr_filt)
				filt_reg <= DATA_IN & `SELF_CLR_MASK;
			if (wr_clkpwr)
				clkpwr_reg <= DATA_IN & `CLKPWR_MASK;
			if (wr_offset)
				offset_reg <= DATA_IN;
			if (wr_gain)
				gain_reg <= DATA_IN;
			if (wr_ovr)
				ovr_reg <= DATA_IN;
		end
	end

	// calibration and sync timers
	// a new command restarts its window from the full count
	// both windows may overlap; they run independently
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			cal_cnt_reg  <= '0;
			sync_cnt_reg <= '0;
		end
		else
		begin
			if (wr_filt && DATA_IN[`BIT_CAL])
				cal_cnt_reg <= CNT_W'(CAL_CYCLES);
			else if (cal_cnt_reg != '0)
				cal_cnt_reg <= cal_cnt_reg - 1'b1;
			if (wr_filt && DATA_IN[`BIT_SYNC])
				sync_cnt_reg <= CNT_W'(SYNC_CYCLES);
			else if (sync_cnt_reg != '0)
				sync_cnt_reg <= sync_cnt_reg - 1'b1;
		end
	end

	// readback selection and read port
	// valid follows every read strobe by one edge
	// read data holds until the next read strobe
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			rdsel_reg  <= RD_RESULT;
			dout_reg   <= 16'h0000;
			dvalid_reg <= 1'b0;
		end
		else
		begin
			dvalid_reg <= RD_STB;
			if (RD_STB)
				dout_reg <= rd_data;
			if (wr_filt)
				rdsel_reg <= rd_pick;
			else if (RD_STB)
				rdsel_reg <= RD_RESULT;
		end
	end

	// registered outputs
	// field outputs are re-timed copies of the stored words, busy flags of the timer counts
	// so each decoded field lags its write by one edge
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			TAP_COUNT_FIELD    <= 4'h0;
			THIRD_STAGE_USE    <= 1'b1;
			FIRST_STAGE_USE    <= 1'b1;
			DECIMATION_FIELD   <= 3'h2;
			CLOCK_DIVIDE_FIELD <= 2'h1;
			DEVICE_SHUTDOWN    <= 1'b1;
			REDUCED_POWER_SEL  <= 1'b0;
			INPUT_AMP_SHUTDOWN <= 1'b1;
			CAL_BUSY           <= 1'b0;
			SYNC_BUSY          <= 1'b0;
		end
		else
		begin
			TAP_COUNT_FIELD    <= filt_reg[`TAP_HI:`TAP_LO];
			THIRD_STAGE_USE    <= filt_reg[`BIT_THIRD_USE];
			FIRST_STAGE_USE    <= filt_reg[`BIT_FIRST_USE];
			DECIMATION_FIELD   <= filt_reg[`DEC_HI:`DEC_LO];
			CLOCK_DIVIDE_FIELD <= clkpwr_reg[`CDIV_HI:`CDIV_LO];
			DEVICE_SHUTDOWN    <= clkpwr_reg[`BIT_SHUTDOWN];
			REDUCED_POWER_SEL  <= clkpwr_reg[`BIT_LOWPWR];
			INPUT_AMP_SHUTDOWN <= clkpwr_reg[`BIT_AMP_OFF];
			CAL_BUSY           <= (cal_cnt_reg != '0);
			SYNC_BUSY          <= (sync_cnt_reg != '0);
		end
	end

	// port drive
	// these outputs are already flip-flops above
	assign DATA_OUT         = dout_reg;
	assign DATA_VALID       = dvalid_reg;
	assign COEFF_WORD       = coeff_reg;
	assign COEFF_STB        = coeff_stb_reg;
	assign LOAD_DONE        = done_reg;
	assign OFFSET_VALUE     = offset_reg;
	assign GAIN_VALUE       = gain_reg;
	assign OVER_RANGE_VALUE = ovr_reg;

endmodule

// >>> tb/ctl_regs_checker.sv
/*
 port relations of the control register bank.
 assumes it is bound into ctl_regs and sees only its ports.
*/
`timescale 1ns/1ns
module ctl_regs_checker
#(
	parameter int CAL_CYCLES  = 20,
	parameter int SYNC_CYCLES = 4
)
(
	// clock and reset
	input wire logic        MCLK,
	input wire logic        RST,
	// host bus
	input wire logic        WR_STB,
	input wire logic        RD_STB,
	input wire logic [15:0] DATA_IN,
	input wire logic [15:0] DATA_OUT,
	input wire logic        DATA_VALID,
	// core side
	input wire logic [15:0] COEFF_WORD,
	input wire logic        COEFF_STB,
	input wire logic        LOAD_DONE,
	input wire logic        CAL_BUSY,
	input wire logic        SYNC_BUSY,
	// decoded fields
	input wire logic [2:0]  DECIMATION_FIELD,
	input wire logic        THIRD_STAGE_USE,
	input wire logic        FIRST_STAGE_USE,
	input wire logic [1:0]  CLOCK_DIVIDE_FIELD,
	input wire logic        DEVICE_SHUTDOWN,
	input wire logic        INPUT_AMP_SHUTDOWN
);
	// last cycle index of the calibration window
	localparam int CAL_M1 = CAL_CYCLES - 1;
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	// busy held over the whole calibration
	sequence cal_run;
		CAL_BUSY throughout (##CAL_M1 1'b1);
	endsequence
	AST_RD_VALID: assert property (RD_STB |=> DATA_VALID)
		else $error("read gave no valid");
	AST_NO_VALID: assert property (!RD_STB |=> !DATA_VALID)
		else $error("valid without read");
	AST_OUT_HOLD: assert property (!$past(RD_STB) |-> $stable(DATA_OUT))
		else $error("read data moved");
	AST_RESET_VAL: assert property ($fell(RST) |-> DECIMATION_FIELD == 3'h2 && THIRD_STAGE_USE
		&& FIRST_STAGE_USE && CLOCK_DIVIDE_FIELD == 2'h1 && DEVICE_SHUTDOWN && INPUT_AMP_SHUTDOWN)
		else $error("wrong reset fields");
	AST_CAL_LEN: assert property ($rose(CAL_BUSY) |-> cal_run ##1 !CAL_BUSY)
		else $error("calibration length wrong");
	AST_SYNC_LEN: assert property ($rose(SYNC_BUSY) |-> SYNC_BUSY[*4] ##1 !SYNC_BUSY)
		else $error("sync length wrong");
	AST_COEFF_FWD: assert property (COEFF_STB |-> $past(WR_STB) && COEFF_WORD == $past(DATA_IN))
		else $error("coefficient word not forwarded");
	AST_LOAD_LAST: assert property (LOAD_DONE |-> COEFF_STB)
		else $error("load end without word");
endmodule

bind ctl_regs ctl_regs_checker #(.CAL_CYCLES(CAL_CYCLES), .SYNC_CYCLES(SYNC_CYCLES)) i_chk (.*);

// >>> tb/host_bus_model.sv
/*
 host side of the parallel bus.
 assumes MCLK from the bench; changes its lines after rising edges.
*/
`timescale 1ns/1ns
module host_bus_model
(
	// clock
	input wire logic        MCLK,
	// bus
	output logic            WR_STB,
	output logic            RD_STB,
	output logic     [15:0] DATA_IN,
	input wire logic [15:0] DATA_OUT,
	input wire logic        DATA_VALID
);
	// idle bus
	initial
	begin
		WR_STB = 1'b0;
		RD_STB = 1'b0;
		DATA_IN = 16'h0000;
	end
	// one word; a released bus shows the inverse
	task automatic wr_word(input logic [15:0] d);
		@(posedge MCLK);
		WR_STB <= 1'b1;
		DATA_IN <= d;
		@(posedge MCLK);
		WR_STB <= 1'b0;
		DATA_IN <= ~d;
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
		wr_word(a);
		wr_word(d);
	endtask
	// read taken one cycle after strobe
	task automatic rd(output logic [15:0] q, output logic v);
		@(posedge MCLK);
		RD_STB <= 1'b1;
		@(posedge MCLK);
		RD_STB <= 1'b0;
		#1;
		q = DATA_OUT;
		v = DATA_VALID;
	endtask
endmodule

// >>> tb/tb_ctl_regs.sv
/*
 self-checking bench of the control register bank.
 assumes the host model drives the bus; the bench drives core words.
*/
`timescale 1ns/1ns
module tb_ctl_regs;
	logic MCLK, RST, WR_STB, RD_STB, DATA_VALID, COEFF_STB, LOAD_DONE, CAL_BUSY, SYNC_BUSY;
	logic THIRD_STAGE_USE, FIRST_STAGE_USE, DEVICE_SHUTDOWN, REDUCED_POWER_SEL, INPUT_AMP_SHUTDOWN;
	logic [15:0] DATA_IN, DATA_OUT, RESULT_IN, STATUS_IN, COEFF_WORD, OFFSET_VALUE, GAIN_VALUE, OVER_RANGE_VALUE;
	logic [3:0] TAP_COUNT_FIELD;
	logic [2:0] DECIMATION_FIELD;
	logic [1:0] CLOCK_DIVIDE_FIELD;
	logic [15:0] q, w, exp_q [4];
	logic v;
	int fails, checks_done, n, stb_n, done_n;
	ctl_regs #(.CAL_CYCLES(20)) i_dut (.*);
	host_bus_model i_host (.*);
	// decoded control words
	wire [15:0] ctl1 = {7'h00, TAP_COUNT_FIELD, THIRD_STAGE_USE, FIRST_STAGE_USE, DECIMATION_FIELD};
	wire [15:0] ctl2 = {10'h000, CLOCK_DIVIDE_FIELD, DEVICE_SHUTDOWN, REDUCED_POWER_SEL, 1'b1, INPUT_AMP_SHUTDOWN};
	initial
	begin
		MCLK = 1'b0;
		forever #25 MCLK = ~MCLK;
	end
	// coefficient strobe counts
	always @(posedge MCLK)
	begin
		stb_n += COEFF_STB;
		done_n += LOAD_DONE;
	end
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	// decoded outputs follow one edge after the data word
	task automatic settle;
		repeat (2) @(posedge MCLK);
		#1;
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// hang limit counts as a mismatch
	initial
	begin
		repeat (20000) @(posedge MCLK);
		fails++;
		complete_run;
	end
	initial
	begin
		RST = 1'b1;
		RESULT_IN = 16'h5A3C;
		STATUS_IN = 16'h0F81;
		repeat (20) @(posedge MCLK);
		RST <= 1'b0;
		#1;
		chk("ctl1", 16'h001A, ctl1);
		chk("ctl2", 16'h009B & 16'h003F, ctl2);
		$display("test reset done");
		// readback of each source, then the result again
		i_host.wr_reg(16'h0003, 16'h1234);
		i_host.wr_reg(16'h0007, 16'hFFFF);
		exp_q = '{16'hCCCC, 16'hA000, 16'h1234, 16'h0F81};
		for (int i = 0; i < 4; i++)
		begin
			i_host.wr_reg(16'h0001, 16'h0079 | (16'h4000 >> i));
			i_host.rd(q, v);
			chk("readback", exp_q[i], q);
			chk("valid", 16'h0001, {15'h0000, v});
			i_host.rd(q, v);
			chk("result", 16'h5A3C, q);
		end
		chk("offset", 16'h1234, OFFSET_VALUE);
		chk("gain", 16'hA000, GAIN_VALUE);
		chk("overrange", 16'hCCCC, OVER_RANGE_VALUE);
		$display("test readback done");
		// decimation codes 0 to 5, third and first stage use set opposite and alternating
		for (int d = 0; d < 6; d++)
		begin
			w = {7'h00, 4'h8, ~d[0], d[0], d[2:0]};
			i_host.wr_reg(16'h0001, w);
			settle;
			chk("ctl1", w, ctl1);
		end
		// allowed clock divides and power bits, bit 1 always one
		for (int c = 0; c < 3; c++)
		begin
			w = {10'h000, c[1:0], c[0], ~c[0], 1'b1, c[1]};
			i_host.wr_reg(16'h0002, w);
			settle;
			chk("ctl2", w, ctl2);
		end
		$display("test fields done");
		// calibration then synchronisation window lengths
		for (int k = 0; k < 2; k++)
		begin
			i_host.wr_reg(16'h0001, 16'h0079 | (16'h0400 >> k));
			n = 0;
			repeat (40)
			begin
				@(posedge MCLK);
				#1;
				n += k ? SYNC_BUSY : CAL_BUSY;
			end
			chk("busy", k ? 16'h0004 : 16'h0014, 16'(n));
		end
		$display("test busy done");
		// six coefficients as word pairs, then the checksum
		stb_n = 0;
		done_n = 0;
		i_host.wr_reg(16'h0001, 16'h8039);
		for (int k = 0; k < 13; k++)
			i_host.wr_word(16'h0300 + 16'(k));
		settle;
		chk("strobes", 16'h000D, 16'(stb_n));
		chk("done", 16'h0001, 16'(done_n));
		chk("last", 16'h030C, COEFF_WORD);
		i_host.wr_reg(16'h0001, 16'h0879);
		i_host.rd(q, v);
		chk("status", 16'h0F81, q);
		$display("test load done");
		complete_run;
	end
endmodule
